// *** logic/system_clock_generation.v ***
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "system_clock_generation_regs.vh"
module system_clock_generation
(
	input wire core_clk_in,
	input wire rst_in,
	input wire [7:0] addr_in,
	input wire [31:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	output reg [31:0] rd_data_out,
	input wire external_clock_input_one_in,
	input wire crystal_input_pin_in,
	input wire internal_clock_in,
	input wire wakeup_clock_in,
	output reg sys_clk_out,
	output reg flash_access_safety_out,
	output reg loop_locked_out,
	output reg clock_switching_out
);
	// Field plus one gives the divide or multiply factor
	function [10:0] factor;
		input [9:0] field;
		begin
			factor = {1'b0, field} + 11'h001;
		end
	endfunction

	function [15:0] band_min;
		input [1:0] band;
		begin
			case (band)
				`BAND_LOW: band_min = `STEP_LOW_MIN;
				`BAND_MID: band_min = `STEP_MID_MIN;
				`BAND_HIGH: band_min = `STEP_HIGH_MIN;
				default: band_min = `STEP_LOW_MIN;
			endcase
		end
	endfunction

	function [15:0] band_max;
		input [1:0] band;
		begin
			case (band)
				`BAND_LOW: band_max = `STEP_LOW_MAX;
				`BAND_MID: band_max = `STEP_MID_MAX;
				`BAND_HIGH: band_max = `STEP_HIGH_MAX;
				default: band_max = `STEP_LOW_MAX;
			endcase
		end
	endfunction

	// Software-visible configuration
	reg [1:0] system_clock_source_select_r;
	reg loop_bypass_r;
	reg ref_internal_r;
	reg [1:0] oscillator_band_select_r;
	reg [3:0] loop_input_divide_field_r;
	reg [6:0] loop_multiply_field_r;
	reg [6:0] loop_output_divide_field_r;
	reg [9:0] prescaler_divide_field_r;

	// Configuration currently driving the output
	reg [1:0] act_sel_r;
	reg act_bypass_r;
	reg act_ref_internal_r;
	reg [9:0] act_k1_r;
	reg [6:0] act_k2_r;
	localparam [1:0] ST_RUN = 2'h0;
	localparam [1:0] ST_PARK = 2'h1;
	localparam [1:0] ST_WAIT = 2'h2;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg restart_r;

	// Loop oscillator
	reg [15:0] acc_r;
	reg [15:0] step_r;
	reg [15:0] step_nxt;
	reg [7:0] vco_cnt_r;
	reg vco_prev_r;
	reg ref_prev_r;
	reg lock_nxt;

	wire ref_w;
	wire ref_rise_w;
	wire vco_w;
	wire vco_rise_w;
	wire loop_on_w;
	wire presc_w;
	wire k2_w;
	wire loop_input_divide_field_w;
	wire loop_input_divide_field_tick_w;
	wire [10:0] n_factor_w;
	wire [15:0] lo_w;
	wire [15:0] hi_w;
	wire mismatch_w;
	reg cand_w;
	reg [31:0] rd_nxt;

	assign ref_w = act_ref_internal_r ? internal_clock_in : crystal_input_pin_in; // R7
	assign ref_rise_w = ref_w & ~ref_prev_r;
	assign vco_w = acc_r[15];
	assign vco_rise_w = vco_w & ~vco_prev_r;
	assign loop_on_w = (act_sel_r == `SEL_OSC) && !act_bypass_r; // R5
	assign n_factor_w = factor({3'h0, loop_multiply_field_r});
	assign lo_w = band_min(oscillator_band_select_r); // R10
	assign hi_w = band_max(oscillator_band_select_r); // R10
	assign mismatch_w = (act_sel_r != system_clock_source_select_r) ||
		(act_bypass_r != loop_bypass_r) ||
		(act_ref_internal_r != ref_internal_r) ||
		(act_k1_r != prescaler_divide_field_r) ||
		(act_k2_r != loop_output_divide_field_r);

	clock_divider u_prescaler
	(
		.clk_in(core_clk_in),
		.rst_in(rst_in),
		.restart_in(restart_r),
		.src_in(ref_w),
		.rise_in(ref_rise_w),
		.factor_in(factor(act_k1_r)), // R3 R4
		.div_out(presc_w),
		.tick_out()
	);

	clock_divider u_input_divider
	(
		.clk_in(core_clk_in),
		.rst_in(rst_in),
		.restart_in(1'b0),
		.src_in(ref_w),
		.rise_in(ref_rise_w),
		.factor_in(factor({6'h00, loop_input_divide_field_r})), // R6
		.div_out(loop_input_divide_field_w),
		.tick_out(loop_input_divide_field_tick_w)
	);

	clock_divider u_output_divider
	(
		.clk_in(core_clk_in),
		.rst_in(rst_in),
		.restart_in(restart_r),
		.src_in(vco_w),
		.rise_in(vco_rise_w),
		.factor_in(factor({3'h0, act_k2_r})), // R8
		.div_out(k2_w),
		.tick_out()
	);

	// Candidate clock for the active configuration
	always @*
	begin
		case (act_sel_r)
			`SEL_DIRECT: cand_w = external_clock_input_one_in; // R1
			`SEL_OSC: cand_w = act_bypass_r ? presc_w : k2_w; // R3 R5
			`SEL_WAKEUP: cand_w = wakeup_clock_in; // R12
			default: cand_w = wakeup_clock_in;
		endcase
	end

	// Register writes
	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			system_clock_source_select_r <= `RST_SEL;
			loop_bypass_r <= `RST_BYPASS;
			ref_internal_r <= `RST_REF_INTERNAL;
			oscillator_band_select_r <= `RST_BAND;
			loop_input_divide_field_r <= `RST_IN_DIV;
			loop_multiply_field_r <= `RST_MUL;
			loop_output_divide_field_r <= `RST_OUT_DIV;
			prescaler_divide_field_r <= `RST_PRE_DIV;
			flash_access_safety_out <= `RST_SAFETY;
		end
		else if (wr_in)
		begin
			case (addr_in)
				`ADDR_SYSTEM_CLOCK_CONFIG:
					system_clock_source_select_r <= wr_data_in[`SEL_MSB:`SEL_LSB];
				`ADDR_LOOP_CONFIG:
				begin
					loop_bypass_r <= wr_data_in[`BYPASS_BIT];
					ref_internal_r <= wr_data_in[`REF_INTERNAL_BIT];
					oscillator_band_select_r <= wr_data_in[`BAND_MSB:`BAND_LSB];
					loop_input_divide_field_r <= wr_data_in[`IN_DIV_MSB:`IN_DIV_LSB];
					loop_multiply_field_r <= wr_data_in[`MUL_MSB:`MUL_LSB];
					loop_output_divide_field_r <= wr_data_in[`OUT_DIV_MSB:`OUT_DIV_LSB];
				end
				`ADDR_PRESCALER:
					prescaler_divide_field_r <= wr_data_in[`PRE_DIV_MSB:`PRE_DIV_LSB];
				// Stored only; software must set it before a fast clock
				`ADDR_STARTUP_MEMORY_CONFIG:
					flash_access_safety_out <= wr_data_in[`SAFETY_BIT]; // R11
				default:
					flash_access_safety_out <= flash_access_safety_out;
			endcase
		end
	end

	// Register reads, data one cycle after the strobe
	always @*
	begin
		rd_nxt = 32'h00000000;
		case (addr_in)
			`ADDR_SYSTEM_CLOCK_CONFIG:
				rd_nxt[`SEL_MSB:`SEL_LSB] = system_clock_source_select_r;
			`ADDR_LOOP_CONFIG:
			begin
				rd_nxt[`BYPASS_BIT] = loop_bypass_r;
				rd_nxt[`REF_INTERNAL_BIT] = ref_internal_r;
				rd_nxt[`BAND_MSB:`BAND_LSB] = oscillator_band_select_r;
				rd_nxt[`IN_DIV_MSB:`IN_DIV_LSB] = loop_input_divide_field_r;
				rd_nxt[`MUL_MSB:`MUL_LSB] = loop_multiply_field_r;
				rd_nxt[`OUT_DIV_MSB:`OUT_DIV_LSB] = loop_output_divide_field_r;
			end
			`ADDR_PRESCALER:
				rd_nxt[`PRE_DIV_MSB:`PRE_DIV_LSB] = prescaler_divide_field_r;
			`ADDR_STARTUP_MEMORY_CONFIG:
				rd_nxt[`SAFETY_BIT] = flash_access_safety_out;
			`ADDR_STATUS:
			begin
				rd_nxt[`STAT_SEL_MSB:`STAT_SEL_LSB] = act_sel_r;
				rd_nxt[`STAT_SWITCH_BIT] = clock_switching_out;
				rd_nxt[`STAT_LOCK_BIT] = loop_locked_out;
				rd_nxt[`STAT_STEP_MSB:`STAT_STEP_LSB] = step_r;
			end
			default:
				rd_nxt = 32'h00000000;
		endcase
	end

	always @(posedge core_clk_in)
	begin
		if (rst_in)
			rd_data_out <= 32'h00000000;
		else if (rd_in)
			rd_data_out <= rd_nxt;
		else
			rd_data_out <= 32'h00000000;
	end

	// Loop frequency control: one step per divided reference period
	always @*
	begin
		step_nxt = step_r;
		lock_nxt = loop_locked_out;
		if (!loop_on_w)
		begin
			step_nxt = lo_w;
			lock_nxt = 1'b0;
		end
		else if (loop_input_divide_field_tick_w)
		begin
			lock_nxt = ({3'h0, vco_cnt_r} == n_factor_w);
			// Small nudges only, so the output frequency slides rather than jumps
			if ({3'h0, vco_cnt_r} < n_factor_w && step_r < hi_w)
				step_nxt = step_r + `STEP_DELTA; // R9
			else if ({3'h0, vco_cnt_r} > n_factor_w && step_r > lo_w)
				step_nxt = step_r - `STEP_DELTA; // R9
		end
		// A band change pulls the step back inside the band at once
		if (step_nxt < lo_w)
			step_nxt = lo_w; // R10
		else if (step_nxt > hi_w)
			step_nxt = hi_w; // R10
	end

	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			acc_r <= 16'h0000;
			step_r <= `STEP_LOW_MIN;
			vco_cnt_r <= 8'h00;
			vco_prev_r <= 1'b0;
			ref_prev_r <= 1'b0;
			loop_locked_out <= 1'b0;
		end
		else
		begin
			acc_r <= loop_on_w ? acc_r + step_r : 16'h0000; // R5
			step_r <= step_nxt;
			vco_prev_r <= vco_w;
			ref_prev_r <= ref_w;
			loop_locked_out <= lock_nxt;
			// Count oscillator cycles per divided reference period, N times P over P
			if (loop_input_divide_field_tick_w || !loop_on_w)
				vco_cnt_r <= {7'h00, vco_rise_w}; // R6
			else if (vco_rise_w && vco_cnt_r != `VCO_CNT_MAX)
				vco_cnt_r <= vco_cnt_r + 8'h01;
		end
	end

	// Switch-over sequencer
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN:
				if (mismatch_w && !cand_w)
					state_nxt = ST_PARK; // R13
			ST_PARK:
				state_nxt = ST_WAIT;
			ST_WAIT:
				if (!cand_w)
					state_nxt = ST_RUN; // R13
			default:
				state_nxt = ST_RUN;
		endcase
	end

	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			state_r <= ST_RUN;
			act_sel_r <= `RST_SEL;
			act_bypass_r <= `RST_BYPASS;
			act_ref_internal_r <= `RST_REF_INTERNAL;
			act_k1_r <= `RST_PRE_DIV;
			act_k2_r <= `RST_OUT_DIV;
			restart_r <= 1'b0;
			sys_clk_out <= 1'b0;
			clock_switching_out <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			restart_r <= 1'b0;
			// Take the new setting only while the output sits low
			if (state_r == ST_RUN && state_nxt == ST_PARK)
			begin
				act_sel_r <= system_clock_source_select_r;
				act_bypass_r <= loop_bypass_r;
				act_ref_internal_r <= ref_internal_r;
				act_k1_r <= prescaler_divide_field_r;
				act_k2_r <= loop_output_divide_field_r;
				restart_r <= 1'b1;
			end
			clock_switching_out <= (state_nxt != ST_RUN);
			// Held low through the change; stretches a low phase, never cuts one
			if (state_nxt == ST_RUN && state_r == ST_RUN)
				sys_clk_out <= cand_w; // R13
			else
				sys_clk_out <= 1'b0;
		end
	end
endmodule

// *** logic/system_clock_generation_regs.vh ***
// How it works
// R1: Source select 11 drives the system clock straight from external clock input one.
// R2: Direct drive and prescale-by-one keep the incoming clock's high and low times.
// R3: Source 10 with bypass set divides the oscillator clock by prescaler field plus one.
// R4: The prescaler factor reaches 1024, the slowest oscillator-derived system clock.
// R5: Source 10 with bypass clear runs the loop and uses its output.
// R6: Loop factor is N over P times K2, each being field plus one.
// R7: Loop reference chooses the crystal input or the internal clock source.
// R8: System clock is the loop oscillator divided by K2.
// R9: The loop pulls its frequency in small steps; a band change moves it into the new band at once.
// R10: Band select picks low 00, middle 01 or high 10 oscillator band.
// R11: Software sets flash access safety before going above 80 MHz.
// R12: Source select 00 runs the system clock from the wakeup clock.
// R13: Source or divider changes switch over without runt clock pulses.
`ifndef SYSTEM_CLOCK_GENERATION_REGS_VH
`define SYSTEM_CLOCK_GENERATION_REGS_VH

`define ADDR_SYSTEM_CLOCK_CONFIG 8'h00
`define ADDR_LOOP_CONFIG 8'h04
`define ADDR_PRESCALER 8'h08
`define ADDR_STARTUP_MEMORY_CONFIG 8'h0C
`define ADDR_STATUS 8'h10

`define SEL_WAKEUP 2'h0
`define SEL_RESERVED 2'h1
`define SEL_OSC 2'h2
`define SEL_DIRECT 2'h3

`define BAND_LOW 2'h0
`define BAND_MID 2'h1
`define BAND_HIGH 2'h2

`define SEL_MSB 1
`define SEL_LSB 0
`define BYPASS_BIT 0
`define REF_INTERNAL_BIT 1
`define BAND_MSB 3
`define BAND_LSB 2
`define IN_DIV_MSB 7
`define IN_DIV_LSB 4
`define MUL_MSB 14
`define MUL_LSB 8
`define OUT_DIV_MSB 21
`define OUT_DIV_LSB 15
`define PRE_DIV_MSB 9
`define PRE_DIV_LSB 0
`define SAFETY_BIT 0

`define STAT_SEL_MSB 1
`define STAT_SEL_LSB 0
`define STAT_SWITCH_BIT 2
`define STAT_LOCK_BIT 3
`define STAT_STEP_MSB 19
`define STAT_STEP_LSB 4

`define RST_SEL 2'h0
`define RST_BYPASS 1'b1
`define RST_REF_INTERNAL 1'b0
`define RST_BAND 2'h0
`define RST_IN_DIV 4'h0
`define RST_MUL 7'h00
`define RST_OUT_DIV 7'h00
`define RST_PRE_DIV 10'h000
`define RST_SAFETY 1'b0

`define STEP_LOW_MIN 16'h0400
`define STEP_LOW_MAX 16'h2000
`define STEP_MID_MIN 16'h0800
`define STEP_MID_MAX 16'h4000
`define STEP_HIGH_MIN 16'h1000
`define STEP_HIGH_MAX 16'h7FFF
`define STEP_DELTA 16'h0001
`define VCO_CNT_MAX 8'hFF

`endif

// *** logic/clock_divider.v ***
`timescale 1ns/100ps
`include "system_clock_generation_regs.vh"
module clock_divider
(
	input wire clk_in,
	input wire rst_in,
	input wire restart_in,
	input wire src_in,
	input wire rise_in,
	input wire [10:0] factor_in,
	output reg div_out,
	output reg tick_out
);
	reg [10:0] cnt_r;
	wire [10:0] last_w;
	wire [10:0] cnt_nxt;
	wire [11:0] half_w;

	assign last_w = factor_in - 11'h001;
	assign cnt_nxt = cnt_r + 11'h001;
	// High phase covers the first half of the input cycles, rounded up
	assign half_w = ({1'b0, factor_in} + 12'h001) >> 1;

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cnt_r <= 11'h000;
			div_out <= 1'b0;
			tick_out <= 1'b0;
		end
		else if (restart_in)
		begin
			// Parked low, first rising input edge opens a full high phase
			cnt_r <= last_w;
			div_out <= 1'b0;
			tick_out <= 1'b0;
		end
		else if (factor_in == 11'h001)
		begin
			div_out <= src_in; // R2
			tick_out <= rise_in;
		end
		else
		begin
			tick_out <= 1'b0;
			if (rise_in)
			begin
				if (cnt_r >= last_w)
				begin
					cnt_r <= 11'h000;
					div_out <= 1'b1;
					tick_out <= 1'b1;
				end
				else
				begin
					cnt_r <= cnt_nxt;
					if ({1'b0, cnt_nxt} >= half_w)
						div_out <= 1'b0;
				end
			end
		end
	end
endmodule

// *** verif/clock_source_model.sv ***
`timescale 1ns/100ps
module clock_source_model
#(
	parameter EXT_HALF = 3,
	parameter XTAL_HALF = 8,
	parameter INT_HALF = 1,
	parameter WU_HALF = 5
)
(
	input wire core_clk_in,
	output wire ext_clk_out,
	output wire xtal_clk_out,
	output wire int_clk_out,
	output wire wu_clk_out
);
	// Oscillators run free, so no reset here
	int cnt_r = 0;
	always @(posedge core_clk_in)
		cnt_r <= cnt_r + 1;
	assign ext_clk_out = (cnt_r / EXT_HALF) % 2 != 0;
	assign xtal_clk_out = (cnt_r / XTAL_HALF) % 2 != 0;
	assign int_clk_out = (cnt_r / INT_HALF) % 2 != 0;
	assign wu_clk_out = (cnt_r / WU_HALF) % 2 != 0;
endmodule

// *** verif/system_clock_generation_sva.sv ***
`timescale 1ns/100ps
module system_clock_generation_sva
(
	input wire core_clk_in,
	input wire rst_in,
	input wire [7:0] addr_in,
	input wire [31:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	input wire [31:0] rd_data_out,
	input wire external_clock_input_one_in,
	input wire crystal_input_pin_in,
	input wire internal_clock_in,
	input wire wakeup_clock_in,
	input wire sys_clk_out,
	input wire flash_access_safety_out,
	input wire loop_locked_out,
	input wire clock_switching_out
);
	reg [1:0] sel_r;
	reg byp_r;
	reg ref_r;
	reg k1z_r;
	reg pend_r;
	reg [3:0] age_r;
	reg [3:0] quiet_r;
	wire cfg_wr = wr_in && (addr_in == 8'h00 || addr_in == 8'h04 || addr_in == 8'h08);
	wire settled = quiet_r == 4'hF;
	wire osc = ref_r ? internal_clock_in : crystal_input_pin_in;
	// A write in the edge of the copy misses it, so only older writes count as taken
	always @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			sel_r <= 2'h0;
			{ref_r, byp_r} <= 2'h1;
			k1z_r <= 1'b1;
			pend_r <= 1'b0;
			age_r <= 4'hF;
			quiet_r <= 4'h0;
		end
		else
		begin
			if (wr_in && addr_in == 8'h00)
				sel_r <= wr_data_in[1:0];
			if (wr_in && addr_in == 8'h04)
				{ref_r, byp_r} <= wr_data_in[1:0];
			if (wr_in && addr_in == 8'h08)
				k1z_r <= wr_data_in[9:0] == 10'h000;
			age_r <= cfg_wr ? 4'h0 : age_r + {3'h0, age_r != 4'hF};
			pend_r <= cfg_wr | (pend_r & ~($rose(clock_switching_out) & (age_r != 4'h0)));
			quiet_r <= (pend_r | cfg_wr | clock_switching_out) ? 4'h0 :
				quiet_r + {3'h0, !settled};
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence rd_at_s(a);
		rd_in && addr_in == a;
	endsequence
	sequence sw_end_s;
		##[1:1000] !clock_switching_out;
	endsequence
	chk_read_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == 32'h0)
		else $error("read data not zero outside a read answer");
	chk_safety_read: assert property (rd_at_s(8'h0C) |=>
		rd_data_out == {31'h0, $past(flash_access_safety_out)})
		else $error("safety read back wrong");
	chk_safety_write: assert property (wr_in && addr_in == 8'h0C |=>
		flash_access_safety_out == $past(wr_data_in[0]))
		else $error("safety bit not stored");
	chk_wakeup_follow: assert property (settled && sel_r == 2'h0 |->
		sys_clk_out == $past(wakeup_clock_in))
		else $error("system clock not following wakeup clock");
	chk_direct_follow: assert property (settled && sel_r == 2'h3 |->
		sys_clk_out == $past(external_clock_input_one_in))
		else $error("system clock not following external clock");
	chk_prescale_one: assert property (settled && sel_r == 2'h2 && byp_r && k1z_r |->
		sys_clk_out == $past(osc, 2))
		else $error("divide by one not following source");
	chk_switch_low: assert property (clock_switching_out |-> !sys_clk_out)
		else $error("system clock high during switch");
	chk_switch_ends: assert property ($rose(clock_switching_out) |-> sw_end_s)
		else $error("switch over did not finish");
	chk_status_source: assert property (rd_at_s(8'h10) ##0 settled |=>
		rd_data_out[2:0] == {1'b0, $past(sel_r)})
		else $error("status source wrong");
endmodule
bind system_clock_generation system_clock_generation_sva i_sva
(
	.core_clk_in(core_clk_in),
	.rst_in(rst_in),
	.addr_in(addr_in),
	.wr_data_in(wr_data_in),
	.wr_in(wr_in),
	.rd_in(rd_in),
	.rd_data_out(rd_data_out),
	.external_clock_input_one_in(external_clock_input_one_in),
	.crystal_input_pin_in(crystal_input_pin_in),
	.internal_clock_in(internal_clock_in),
	.wakeup_clock_in(wakeup_clock_in),
	.sys_clk_out(sys_clk_out),
	.flash_access_safety_out(flash_access_safety_out),
	.loop_locked_out(loop_locked_out),
	.clock_switching_out(clock_switching_out)
);

// *** verif/system_clock_generation_tb.sv ***
`timescale 1ns/100ps
module system_clock_generation_tb;
	localparam EH = 3;
	localparam XH = 8;
	localparam IH = 1;
	localparam WH = 5;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wr_data_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	wire [31:0] rd_data_out;
	wire ext_clk;
	wire xtal_clk;
	wire int_clk;
	wire wu_clk;
	wire sys_clk_out;
	wire flash_access_safety_out;
	wire loop_locked_out;
	wire clock_switching_out;
	wire [2:0] obs = {loop_locked_out, clock_switching_out, sys_clk_out};
	int miscompares = 0;
	int n_tests = 0;
	int t;
	clock_source_model #(.EXT_HALF(EH), .XTAL_HALF(XH), .INT_HALF(IH), .WU_HALF(WH)) i_src
	(
		.core_clk_in(core_clk_in),
		.ext_clk_out(ext_clk),
		.xtal_clk_out(xtal_clk),
		.int_clk_out(int_clk),
		.wu_clk_out(wu_clk)
	);
	system_clock_generation i_dut
	(
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.addr_in(addr_in),
		.wr_data_in(wr_data_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rd_data_out(rd_data_out),
		.external_clock_input_one_in(ext_clk),
		.crystal_input_pin_in(xtal_clk),
		.internal_clock_in(int_clk),
		.wakeup_clock_in(wu_clk),
		.sys_clk_out(sys_clk_out),
		.flash_access_safety_out(flash_access_safety_out),
		.loop_locked_out(loop_locked_out),
		.clock_switching_out(clock_switching_out)
	);
	initial
		forever #12.5 core_clk_in = ~core_clk_in;
	task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			n_tests++;
			if (seen !== exp)
			begin
				miscompares++;
				$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		begin
			addr_in <= a;
			wr_data_in <= d;
			wr_in <= 1'b1;
			@(posedge core_clk_in);
			wr_in <= 1'b0;
			#1;
		end
	endtask
	task automatic rd(input [7:0] a, input [31:0] m, input [31:0] e, input string nm);
		begin
			addr_in <= a;
			rd_in <= 1'b1;
			@(posedge core_clk_in);
			rd_in <= 1'b0;
			#1;
			chk(nm, rd_data_out & m, e);
		end
	endtask
	task automatic wait_bit(input int i, input logic v, inout int n, input int lim);
		begin
			while (obs[i] !== v && n < lim)
			begin
				@(posedge core_clk_in);
				#1;
				n++;
			end
		end
	endtask
	// Margin lets the restarted divider settle before measuring
	task automatic wait_sw;
		begin
			t = 0;
			wait_bit(1, 1'b1, t, 1500);
			chk("switch_start", {31'h0, obs[1]}, 32'h1);
			wait_bit(1, 1'b0, t, 3000);
			repeat (4) @(posedge core_clk_in);
			#1;
			chk("switch_done", {31'h0, clock_switching_out}, 32'h0);
		end
	endtask
	task automatic period(input string nm, input int ep, input int eh);
		int h;
		begin
			t = 0;
			wait_bit(0, 1'b0, t, 9000);
			wait_bit(0, 1'b1, t, 9000);
			t = 0;
			wait_bit(0, 1'b0, t, 9000);
			h = t;
			wait_bit(0, 1'b1, t, 9000);
			chk({nm, "_high"}, h, eh);
			chk(nm, t, ep);
			$display("test %s done", nm);
		end
	endtask
	task automatic summarize;
		begin
			$display("checks %0d mismatches %0d", n_tests, miscompares);
			if (miscompares == 0 && n_tests > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial
	begin
		repeat (60000) @(posedge core_clk_in);
		miscompares++;
		summarize;
	end
	initial
	begin
		repeat (5) @(posedge core_clk_in);
		rst_in <= 1'b0;
		@(posedge core_clk_in);
		rd(8'h00, 32'hFFFFFFFF, 32'h0, "sel_reset");
		rd(8'h04, 32'hFFFFFFFF, 32'h1, "loop_reset");
		rd(8'h08, 32'hFFFFFFFF, 32'h0, "k1_reset");
		rd(8'h0C, 32'hFFFFFFFF, 32'h0, "safety_reset");
		rd(8'h10, 32'hF, 32'h0, "status_reset");
		rd(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
		period("wakeup", 2 * WH, WH);
		wr(8'h0C, 32'h1);
		rd(8'h0C, 32'hFFFFFFFF, 32'h1, "safety");
		wr(8'h00, 32'h3);
		wait_sw;
		rd(8'h10, 32'h7, 32'h3, "status_direct");
		period("direct", 2 * EH, EH);
		wr(8'h00, 32'h2);
		wait_sw;
		period("xtal_k1", 2 * XH, XH);
		wr(8'h04, 32'h3);
		wait_sw;
		period("int_k1", 2 * IH, IH);
		wr(8'h08, 32'h3);
		wait_sw;
		period("int_k4", 8 * IH, 4 * IH);
		wr(8'h08, 32'h3FF);
		wait_sw;
		period("int_k1024", 2048 * IH, 1024 * IH);
		for (int b = 0; b < 3; b++)
		begin
			wr(8'h04, 32'h8001 | (b << 2));
			rd(8'h04, 32'hFFFFFFFF, 32'h8001 | (b << 2), "band");
		end
		// High band, P=1 N=1 K2=2: loop settles at one vco cycle per crystal period
		wr(8'h04, 32'h8008);
		wait_sw;
		t = 0;
		wait_bit(2, 1'b1, t, 4000);
		rd(8'h10, 32'hF, 32'hA, "status_loop");
		period("loop", 4 * XH, 2 * XH);
		// Loop off and on again so P=2 N=2 K2=2 start clean; bypass leg uses the fast source
		wr(8'h04, 32'h811B);
		wait_sw;
		wr(8'h04, 32'h8118);
		wait_sw;
		t = 0;
		wait_bit(2, 1'b1, t, 4000);
		chk("locked_pn", {31'h0, loop_locked_out}, 32'h1);
		period("loop_pn", 4 * XH, 2 * XH);
		summarize;
	end
endmodule
